// File: logic/imucf_cfg.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef IMUCF_CFG_SVH
`define IMUCF_CFG_SVH
`define IMUCF_PAGE_OUTPUT     16'h0000
`define IMUCF_PAGE_CONTROL    16'h0003
`define IMUCF_PAGE_COEF_FIRST 16'h0005
`define IMUCF_PAGE_COEF_LAST  16'h000c
`define IMUCF_ADDR_PAGE       6'h00
`define IMUCF_ADDR_DATA_CNT   6'h02
`define IMUCF_ADDR_GYRO_X     6'h09
`define IMUCF_ADDR_GYRO_Y     6'h0b
`define IMUCF_ADDR_GYRO_Z     6'h0d
`define IMUCF_ADDR_ACCL_X     6'h0f
`define IMUCF_ADDR_ACCL_Y     6'h11
`define IMUCF_ADDR_ACCL_Z     6'h13
`define IMUCF_ADDR_PINFN      6'h03
`define IMUCF_ADDR_DIO_STAT   6'h04
`define IMUCF_ADDR_MISC       6'h05
`define IMUCF_ADDR_DEC        6'h06
`define IMUCF_ADDR_BANK_LO    6'h0b
`define IMUCF_ADDR_BANK_HI    6'h0c
`define IMUCF_COEF_BASE       6'h04
`define IMUCF_COEF_PER_PAGE   9'h03c
`define IMUCF_TAPS            9'h078
`define IMUCF_COEF_UNITY      16'h4000
`define IMUCF_MISC_LING_BIT   7
`define IMUCF_MISC_POP_BIT    6
`define IMUCF_RST_MISC        16'h00c0
`define IMUCF_RST_DEC         16'h0000
`define IMUCF_RST_PINFN       16'h0009
`define IMUCF_RST_BANK        16'h0000
`define IMUCF_PINFN_EN_BIT    3
`define IMUCF_PINFN_POL_BIT   2
`define IMUCF_BANK_EN_BIT     2
`define IMUCF_CLK_NS          100
`define IMUCF_DRDY_NS         1000
`define IMUCF_DRDY_CYC ((`IMUCF_DRDY_NS + `IMUCF_CLK_NS - 1) / `IMUCF_CLK_NS)
`endif

// File: logic/imucf_pkg.sv
// types shared by the calibration, filter and serial register block
`default_nettype none
package imucf_pkg;
  typedef logic [2:0][15:0] imucf_axes_type;
  typedef logic [8:0][15:0] imucf_mat_type;
  typedef struct packed {
    imucf_axes_type gyro;
    imucf_axes_type accel;
  } imucf_sample_type;
  typedef enum logic [1:0] {
    IMUCF_IDLE = 2'b00,
    IMUCF_MAC  = 2'b01,
    IMUCF_DIV  = 2'b10,
    IMUCF_PUB  = 2'b11
  } imucf_fir_state_type;
endpackage : imucf_pkg
`default_nettype wire

// File: logic/imucf_top.sv
// calibration, fir and decimation chain with paged spi register file
`default_nettype none
`include "imucf_cfg.svh"

module imucf_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (wr_ff - rd_ff) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data  = mem[rd_ff[AW-1:0]];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wr_ff[AW-1:0]] <= in_data;
  end
endmodule : imucf_fifo

module imucf_top
  import imucf_pkg::*;
#(
  // factory coefficients, q2.14; they live only here, no register reaches them
  parameter imucf_mat_type  GYRO_M = 144'h4000_0000_0000_0000_4000_0000_0000_0000_4000,
  parameter imucf_axes_type GYRO_B = '0,
  parameter imucf_mat_type  GYRO_G = '0,
  parameter imucf_mat_type  ACCL_M = 144'h4000_0000_0000_0000_4000_0000_0000_0000_4000,
  parameter imucf_axes_type ACCL_B = '0,
  parameter imucf_mat_type  ACCL_P = '0,
  parameter int             FIFO_DEPTH = 8,
  parameter int             DEC_W      = 11
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             SAMPLE_VALID,
  output logic                  SAMPLE_READY,
  input  wire imucf_sample_type SAMPLE_RAW,
  input  wire logic             SCLK,
  input  wire logic             CS_N,
  input  wire logic             DIN,
  output logic                  DOUT,
  input  wire logic [3:0]       DIO_I,
  output logic [3:0]            DIO_O,
  output logic [3:0]            DIO_OE_N
);
  if (DEC_W < 1 || DEC_W > 16) begin : g_chk
    $error("decimation width out of range");
  end

  function automatic logic signed [15:0] sat(input logic signed [47:0] v);
    logic signed [47:0] s;
    s = v >>> 14;
    if (s > 48'sh7fff) return 16'sh7fff;
    if (s < -48'sh8000) return -16'sh8000;
    return s[15:0];
  endfunction : sat

  // control registers
  logic [15:0] page_ff, misc_ff, dec_ff, pinfn_ff, bank_lo_ff, bank_hi_ff;
  logic [15:0] data_cnt_ff;
  logic [7:0]  low_hold_ff;

  // calibration, accel first so the gyro sees this sample's accel
  logic signed [15:0] gprev_ff [0:2];
  logic signed [16:0] gsq [0:2];
  logic signed [47:0] asum [0:2];
  logic signed [47:0] gsum [0:2];
  imucf_sample_type   cal;
  always_comb begin
    for (int j = 0; j < 3; j++) begin
      gsq[j] = 17'((32'(gprev_ff[j]) * gprev_ff[j]) >>> 15);
    end
    for (int i = 0; i < 3; i++) begin
      asum[i] = 48'($signed(ACCL_B[i])) <<< 14;
      for (int j = 0; j < 3; j++) begin
        asum[i] += 48'($signed(ACCL_M[3*i+j])) * $signed(SAMPLE_RAW.accel[j]);
        if (misc_ff[`IMUCF_MISC_POP_BIT] && i != j) begin
          asum[i] += 48'($signed(ACCL_P[3*i+j])) * gsq[j];
        end
      end
      cal.accel[i] = sat(asum[i]);
    end
    for (int i = 0; i < 3; i++) begin
      gsum[i] = 48'($signed(GYRO_B[i])) <<< 14;
      for (int j = 0; j < 3; j++) begin
        gsum[i] += 48'($signed(GYRO_M[3*i+j])) * $signed(SAMPLE_RAW.gyro[j]);
        if (misc_ff[`IMUCF_MISC_LING_BIT]) begin
          gsum[i] += 48'($signed(GYRO_G[3*i+j])) * $signed(cal.accel[j]);
        end
      end
      cal.gyro[i] = sat(gsum[i]);
    end
  end

  // calibrated sets queue here; the filter engine drains one per pass
  imucf_fir_state_type state_ff;
  imucf_sample_type    fifo_data;
  logic                fifo_valid;
  wire fifo_ready = state_ff == IMUCF_IDLE;
  imucf_fifo #(.WIDTH(96), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .in_valid  (SAMPLE_VALID),
    .in_ready  (SAMPLE_READY),
    .in_data   (cal),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      for (int j = 0; j < 3; j++) gprev_ff[j] <= '0;
    end else if (SAMPLE_VALID && SAMPLE_READY) begin
      for (int j = 0; j < 3; j++) gprev_ff[j] <= cal.gyro[j];
    end
  end

  // fir engine: channels 0..2 accel, 3..5 gyro, one tap per clock
  logic [15:0]        coef_mem [0:479];
  logic [479:0]       coef_set_ff;
  logic signed [15:0] hist_ff [0:5][0:119];
  logic [2:0]         ch_ff;
  logic [6:0]         tap_ff, wp_ff;
  logic signed [47:0] acc_ff;
  logic signed [31:0] dsum_ff [0:5];
  logic signed [15:0] stage_ff [0:5];
  logic signed [15:0] out_ff [0:5];
  logic [DEC_W-1:0]   dcnt_ff;
  logic [7:0]         drdy_cnt_ff;
  wire [5:0][15:0] fifo_words = {fifo_data.gyro, fifo_data.accel};
  wire [DEC_W-1:0] dec_set = dec_ff[DEC_W-1:0];
  wire [2:0] bank_fld = (ch_ff >= 3'd3) ? bank_lo_ff[3*(ch_ff-3'd3)+:3]
                                        : bank_hi_ff[3*ch_ff+:3];
  wire [7:0] hidx8 = (wp_ff >= tap_ff) ? 8'(wp_ff - tap_ff)
                                       : 8'(8'(wp_ff) + 8'd120 - 8'(tap_ff));
  wire [6:0] hidx = hidx8[6:0];
  wire [8:0] fir_cidx = 9'(bank_fld[1:0]) * `IMUCF_TAPS + 9'(tap_ff);
  wire [15:0] coef_val = coef_set_ff[fir_cidx] ? coef_mem[fir_cidx] :
                         (tap_ff == 7'd0) ? `IMUCF_COEF_UNITY : 16'h0000;
  wire signed [47:0] acc_nxt = acc_ff + 48'($signed(coef_val)) * hist_ff[ch_ff][hidx];
  wire signed [15:0] fir_val = bank_fld[`IMUCF_BANK_EN_BIT] ? sat(acc_nxt)
                                                            : hist_ff[ch_ff][wp_ff];
  wire last_tap = tap_ff == 7'(`IMUCF_TAPS - 9'h001);
  wire signed [31:0] divisor = $signed(32'(dec_set) + 32'h1);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      for (int c = 0; c < 6; c++) begin
        for (int t = 0; t < 120; t++) hist_ff[c][t] <= '0;
      end
    end else if (fifo_valid && fifo_ready) begin
      for (int c = 0; c < 6; c++) hist_ff[c][wp_ff] <= fifo_words[c];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_ff    <= IMUCF_IDLE;
      ch_ff       <= '0;
      tap_ff      <= '0;
      wp_ff       <= '0;
      acc_ff      <= '0;
      dcnt_ff     <= '0;
      data_cnt_ff <= '0;
      drdy_cnt_ff <= '0;
      for (int c = 0; c < 6; c++) begin
        dsum_ff[c]  <= '0;
        stage_ff[c] <= '0;
        out_ff[c]   <= '0;
      end
    end else begin
      if (drdy_cnt_ff != 8'h00) drdy_cnt_ff <= drdy_cnt_ff - 8'h01;
      case (state_ff)
        IMUCF_IDLE: begin
          ch_ff  <= '0;
          tap_ff <= '0;
          acc_ff <= '0;
          if (fifo_valid) state_ff <= IMUCF_MAC;
        end
        IMUCF_MAC: begin
          acc_ff <= acc_nxt;
          tap_ff <= tap_ff + 7'd1;
          if (last_tap) begin
            dsum_ff[ch_ff] <= dsum_ff[ch_ff] + 32'(fir_val);
            acc_ff <= '0;
            tap_ff <= '0;
            ch_ff  <= ch_ff + 3'd1;
            if (ch_ff == 3'd5) begin
              ch_ff <= '0;
              wp_ff <= (wp_ff == 7'd119) ? 7'd0 : wp_ff + 7'd1;
              if (dcnt_ff >= dec_set) begin
                state_ff <= IMUCF_DIV;
              end else begin
                dcnt_ff  <= dcnt_ff + 1'b1;
                state_ff <= IMUCF_IDLE;
              end
            end
          end
        end
        IMUCF_DIV: begin
          // one divider shared by all six channels, one per clock
          stage_ff[ch_ff] <= 16'(dsum_ff[ch_ff] / divisor);
          dsum_ff[ch_ff]  <= '0;
          ch_ff <= ch_ff + 3'd1;
          if (ch_ff == 3'd5) state_ff <= IMUCF_PUB;
        end
        IMUCF_PUB: begin
          for (int c = 0; c < 6; c++) out_ff[c] <= stage_ff[c];
          data_cnt_ff <= data_cnt_ff + 16'h0001;
          drdy_cnt_ff <= 8'(`IMUCF_DRDY_CYC);
          dcnt_ff     <= '0;
          ch_ff       <= '0;
          state_ff    <= IMUCF_IDLE;
        end
        default: state_ff <= IMUCF_IDLE;
      endcase
    end
  end

  // spi slave, oversampled: pins pass two flops before any logic
  logic [2:0]  sclk_sy_ff, cs_sy_ff;
  logic [1:0]  din_sy_ff;
  logic [3:0]  dio_s1_ff, dio_s2_ff;
  logic [14:0] rx_ff;
  logic [15:0] tx_ff, rd_data_ff;
  logic [3:0]  bit_ff;
  logic        dout_ff;
  wire cs_act  = !cs_sy_ff[1];
  wire cs_fall = !cs_sy_ff[1] && cs_sy_ff[2];
  wire s_rise  = sclk_sy_ff[1] && !sclk_sy_ff[2];
  wire s_fall  = !sclk_sy_ff[1] && sclk_sy_ff[2];
  wire [15:0] cmd = {rx_ff, din_sy_ff[1]};
  wire done    = cs_act && s_rise && bit_ff == 4'hf;
  wire cmd_wr  = cmd[15];
  wire [5:0] cmd_w = cmd[14:9];
  wire cmd_hi  = cmd[8];
  wire [7:0] cmd_d = cmd[7:0];
  wire [15:0] wr_word = {cmd_d, low_hold_ff};

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sclk_sy_ff <= 3'h7;
      cs_sy_ff   <= 3'h7;
      din_sy_ff  <= '0;
      dio_s1_ff  <= '0;
      dio_s2_ff  <= '0;
    end else begin
      sclk_sy_ff <= {sclk_sy_ff[1:0], SCLK};
      cs_sy_ff   <= {cs_sy_ff[1:0], CS_N};
      din_sy_ff  <= {din_sy_ff[0], DIN};
      dio_s1_ff  <= DIO_I;
      dio_s2_ff  <= dio_s1_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_ff   <= '0;
      tx_ff   <= '0;
      bit_ff  <= '0;
      dout_ff <= 1'b1;
    end else begin
      if (cs_fall) begin
        bit_ff <= '0;
        tx_ff  <= rd_data_ff;
      end else if (cs_act && s_fall) begin
        dout_ff <= tx_ff[15];
        tx_ff   <= {tx_ff[14:0], 1'b0};
      end else if (cs_act && s_rise) begin
        rx_ff  <= cmd[14:0];
        bit_ff <= bit_ff + 4'h1;
      end
    end
  end

  // register read map of the selected page
  wire is_out  = page_ff == `IMUCF_PAGE_OUTPUT;
  wire is_ctl  = page_ff == `IMUCF_PAGE_CONTROL;
  wire is_coef = page_ff >= `IMUCF_PAGE_COEF_FIRST;
  wire [15:0] pg_off = page_ff - `IMUCF_PAGE_COEF_FIRST;
  wire [8:0] acc_cidx = 9'(pg_off[2:1]) * `IMUCF_TAPS + 9'(pg_off[0]) * `IMUCF_COEF_PER_PAGE
                      + 9'(cmd_w - `IMUCF_COEF_BASE);
  wire coef_hit = is_coef && cmd_w >= `IMUCF_COEF_BASE;
  wire [15:0] coef_rd = coef_set_ff[acc_cidx] ? coef_mem[acc_cidx] :
                        (acc_cidx == 9'd0 || acc_cidx == 9'd120 || acc_cidx == 9'd240
                         || acc_cidx == 9'd360) ? `IMUCF_COEF_UNITY : 16'h0000;
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (cmd_w == `IMUCF_ADDR_PAGE) rd_val = page_ff;
    else if (coef_hit) rd_val = coef_rd;
    else if (is_out) begin
      case (cmd_w)
        `IMUCF_ADDR_DATA_CNT: rd_val = data_cnt_ff;
        `IMUCF_ADDR_GYRO_X:   rd_val = out_ff[3];
        `IMUCF_ADDR_GYRO_Y:   rd_val = out_ff[4];
        `IMUCF_ADDR_GYRO_Z:   rd_val = out_ff[5];
        `IMUCF_ADDR_ACCL_X:   rd_val = out_ff[0];
        `IMUCF_ADDR_ACCL_Y:   rd_val = out_ff[1];
        `IMUCF_ADDR_ACCL_Z:   rd_val = out_ff[2];
        default:              rd_val = 16'h0000;
      endcase
    end else if (is_ctl) begin
      case (cmd_w)
        `IMUCF_ADDR_PINFN:    rd_val = pinfn_ff;
        `IMUCF_ADDR_DIO_STAT: rd_val = {12'h000, dio_s2_ff};
        `IMUCF_ADDR_MISC:     rd_val = misc_ff;
        `IMUCF_ADDR_DEC:      rd_val = dec_ff;
        `IMUCF_ADDR_BANK_LO:  rd_val = bank_lo_ff;
        `IMUCF_ADDR_BANK_HI:  rd_val = bank_hi_ff;
        default:              rd_val = 16'h0000;
      endcase
    end
  end

  // a word commits on its high byte; the low byte waits in low_hold_ff
  wire commit   = done && cmd_wr && cmd_hi;
  wire wr_ctl   = commit && is_ctl;
  wire wr_coef  = commit && coef_hit;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      page_ff     <= `IMUCF_PAGE_OUTPUT;
      misc_ff     <= `IMUCF_RST_MISC;
      dec_ff      <= `IMUCF_RST_DEC;
      pinfn_ff    <= `IMUCF_RST_PINFN;
      bank_lo_ff  <= `IMUCF_RST_BANK;
      bank_hi_ff  <= `IMUCF_RST_BANK;
      low_hold_ff <= '0;
      rd_data_ff  <= '0;
      coef_set_ff <= '0;
    end else if (done) begin
      if (!cmd_wr) rd_data_ff <= rd_val;
      if (cmd_wr && !cmd_hi) low_hold_ff <= cmd_d;
      // the page code fits the low byte, so it takes effect at once
      if (cmd_wr && !cmd_hi && cmd_w == `IMUCF_ADDR_PAGE
          && 16'(cmd_d) <= `IMUCF_PAGE_COEF_LAST) begin
        page_ff <= 16'(cmd_d);
      end
      if (wr_coef) coef_set_ff[acc_cidx] <= 1'b1;
      if (wr_ctl) begin
        case (cmd_w)
          `IMUCF_ADDR_PINFN:   pinfn_ff   <= wr_word;
          `IMUCF_ADDR_MISC:    misc_ff    <= wr_word;
          `IMUCF_ADDR_DEC:     dec_ff     <= wr_word;
          `IMUCF_ADDR_BANK_LO: bank_lo_ff <= wr_word;
          `IMUCF_ADDR_BANK_HI: bank_hi_ff <= wr_word;
          default:             ;
        endcase
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (wr_coef) coef_mem[acc_cidx] <= wr_word;
  end

  // data ready: pin, polarity and enable from the pin function register
  logic [3:0] dio_o_ff, dio_oe_n_ff;
  wire [3:0] pin_sel = 4'h1 << pinfn_ff[1:0];
  wire drdy_act = drdy_cnt_ff != 8'h00;
  wire drdy_lvl = pinfn_ff[`IMUCF_PINFN_POL_BIT] ? drdy_act : !drdy_act;
  wire drdy_en  = pinfn_ff[`IMUCF_PINFN_EN_BIT];
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      dio_o_ff    <= '0;
      dio_oe_n_ff <= 4'hf;
    end else begin
      dio_o_ff    <= pin_sel & {4{drdy_lvl}};
      dio_oe_n_ff <= ~(pin_sel & {4{drdy_en}});
    end
  end
  assign DIO_O    = dio_o_ff;
  assign DIO_OE_N = dio_oe_n_ff;
  assign DOUT     = dout_ff;
endmodule : imucf_top
`default_nettype wire

// File: test/imucf_properties.sv
// port checks for the calibration, filter and paged serial block
`default_nettype none
module imucf_properties
  import imucf_pkg::*;
(
  input wire logic             CLK,
  input wire logic             RESET_N,
  input wire logic             SAMPLE_VALID,
  input wire logic             SAMPLE_READY,
  input wire imucf_sample_type SAMPLE_RAW,
  input wire logic             SCLK,
  input wire logic             CS_N,
  input wire logic             DIN,
  input wire logic             DOUT,
  input wire logic [3:0]       DIO_I,
  input wire logic [3:0]       DIO_O,
  input wire logic [3:0]       DIO_OE_N
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  logic        drdy_ff;
  logic [10:0] gap_ff;
  logic [10:0] nxt_gap;
  // saturates so a long idle stretch never wraps into a false short gap
  assign nxt_gap = (drdy_ff && !DIO_O[1]) ? 11'h000 :
                   (gap_ff == 11'h7ff) ? gap_ff : gap_ff + 11'h001;
  always_ff @(posedge CLK) begin
    drdy_ff <= RESET_N ? DIO_O[1] : 1'b0;
    gap_ff  <= RESET_N ? nxt_gap : 11'h000;
  end
  sequence drdy_low_s;
    (!DIO_O[1]) [*8] ##1 !DIO_O[1] ##1 !DIO_O[1];
  endsequence
  sequence frame_idle_s;
    CS_N [*6];
  endsequence
  reset_pins_a: assert property ($rose(RESET_N) |-> DOUT && SAMPLE_READY)
    else $error("dout or sample ready wrong after reset");
  reset_dio_a: assert property ($rose(RESET_N) |-> DIO_OE_N == 4'hf && DIO_O == 4'h0)
    else $error("digital io wrong after reset");
  oe_drive_a: assert property ($past(RESET_N) |-> DIO_OE_N == 4'hd)
    else $error("only pin two may be driven");
  drdy_pulse_a: assert property ($fell(DIO_O[1]) |-> drdy_low_s ##1 DIO_O[1])
    else $error("data ready pulse not ten cycles");
  pulse_gap_a: assert property ($fell(DIO_O[1]) |-> gap_ff >= 11'h2d0)
    else $error("data ready pulses too close");
  dout_hold_a: assert property ($rose(SCLK) && !CS_N |-> ##1 $stable(DOUT) [*3])
    else $error("dout moved while serial clock high");
  dout_idle_a: assert property (frame_idle_s |-> $stable(DOUT))
    else $error("dout moved between frames");
  ready_fall_a: assert property ($fell(SAMPLE_READY) |-> $past(SAMPLE_VALID))
    else $error("sample ready fell without an offer");
endmodule : imucf_properties

bind imucf_top imucf_properties u_props (
  .CLK(CLK), .RESET_N(RESET_N), .SAMPLE_VALID(SAMPLE_VALID),
  .SAMPLE_READY(SAMPLE_READY), .SAMPLE_RAW(SAMPLE_RAW), .SCLK(SCLK), .CS_N(CS_N),
  .DIN(DIN), .DOUT(DOUT), .DIO_I(DIO_I), .DIO_O(DIO_O), .DIO_OE_N(DIO_OE_N)
);
`default_nettype wire

// File: test/imucf_host.sv
// spi master model of the embedded host, mode 3, 16-bit words
`default_nettype none
module imucf_host (
  output logic      SCLK,
  output logic      CS_N,
  output logic      DIN,
  input  wire logic DOUT
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    SCLK = 1'b1;
    CS_N = 1'b1;
    DIN  = 1'b0;
  end
  // 800 ns period keeps far under the 15 MHz ceiling; 37 ns skew avoids the CLK edges
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    #37;
    CS_N = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      SCLK = 1'b0;
      DIN  = w[i];
      #400;
      SCLK = 1'b1;
      r[i] = DOUT;
      #400;
    end
    CS_N = 1'b1;
    // a released line must not keep looking like valid data
    DIN  = ~DIN;
    #700;
  endtask : xfer
endmodule : imucf_host
`default_nettype wire

// File: test/imucf_top_tb.sv
// self-checking bench: host model on spi, sample source on the stream side
`default_nettype none
module imucf_top_tb
  import imucf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic             CLK;
  logic             RESET_N;
  logic             SAMPLE_VALID;
  logic             SAMPLE_READY;
  imucf_sample_type SAMPLE_RAW;
  wire logic        SCLK;
  wire logic        CS_N;
  wire logic        DIN;
  logic             DOUT;
  logic [3:0]       DIO_I;
  logic [3:0]       DIO_O;
  logic [3:0]       DIO_OE_N;
  logic [15:0]      rd_val;
  logic [15:0]      e;
  logic [15:0]      q [$];
  event             rd_ev;
  int               num_errors;
  int               n_tests;
  int               seed;
  int               k;
  bit               tk;
  imucf_sample_type s1;
  imucf_sample_type s2;

  imucf_top #(.GYRO_G({9{16'h4000}})) uut (
    .CLK(CLK), .RESET_N(RESET_N), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .SAMPLE_RAW(SAMPLE_RAW), .SCLK(SCLK), .CS_N(CS_N),
    .DIN(DIN), .DOUT(DOUT), .DIO_I(DIO_I), .DIO_O(DIO_O), .DIO_OE_N(DIO_OE_N)
  );
  imucf_host host (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  always @(rd_ev) begin
    n_tests++;
    e = (q.size() != 0) ? q.pop_front() : ~rd_val;
    if (rd_val !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, rd_val, e);
    end
  end

  task automatic post(input logic [15:0] got, input logic [15:0] exp);
    q.push_back(exp);
    rd_val = got;
    ->rd_ev;
    #1;
  endtask : post

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer(16'h0000, r);
    post(r, exp);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] r;
    host.xfer({1'b1, a, v[7:0]}, r);
    host.xfer({1'b1, a | 7'h01, v[15:8]}, r);
  endtask : wr

  task automatic pg(input logic [7:0] p);
    logic [15:0] r;
    host.xfer({8'h80, p}, r);
  endtask : pg

  function automatic imucf_sample_type rnd();
    imucf_sample_type s;
    for (int j = 0; j < 3; j++) begin
      s.gyro[j]  = 16'(($random(seed) % 500) * 2);
      s.accel[j] = 16'(($random(seed) % 500) * 2);
    end
    return s;
  endfunction : rnd

  function automatic int cal(imucf_sample_type s, int j, bit lin, bit half);
    int v;
    v = $signed(s.gyro[j]);
    if (lin) v += $signed(s.accel[0]) + $signed(s.accel[1]) + $signed(s.accel[2]);
    if (half && j == 0) v = v / 2;
    return v;
  endfunction : cal

  task automatic send(input imucf_sample_type s);
    logic ok;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_RAW   <= s;
    do begin
      @(negedge CLK);
      ok = SAMPLE_READY;
      @(posedge CLK);
    end while (ok !== 1'b1);
    SAMPLE_VALID <= 1'b0;
  endtask : send

  task automatic wait_drdy();
    int i;
    i = 0;
    while (DIO_O[1] !== 1'b0 && i < 2000) begin
      @(negedge CLK);
      i++;
    end
    while (DIO_O[1] !== 1'b1 && i < 2000) begin
      @(negedge CLK);
      i++;
    end
    post(16'(i < 2000), 16'h0001);
  endtask : wait_drdy

  // one sample set, or the truncated mean of two, through identity scale (gyro x halved when half is set), plus the accel sum on each gyro axis when lin is set
  task automatic check_set(input int n, input bit lin, input bit half);
    int v;
    for (int j = 0; j < 3; j++) begin
      v = cal(s1, j, lin, half) + ((n == 2) ? cal(s2, j, lin, half) : 0);
      rd(7'h12 + 7'(4 * j), 16'(v / n));
      v = $signed(s1.accel[j]) + ((n == 2) ? $signed(s2.accel[j]) : 0);
      rd(7'h1e + 7'(4 * j), 16'(v / n));
    end
  endtask : check_set

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  initial begin
    #6000000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    RESET_N      = 1'b0;
    SAMPLE_VALID = 1'b0;
    SAMPLE_RAW   = '0;
    DIO_I        = 4'h0;
    num_errors   = 0;
    n_tests      = 0;
    seed         = 32'hfa08d3f3;
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    k = $random(seed);
    DIO_I <= 4'(k);
    repeat (2) @(posedge CLK);
    rd(7'h00, 16'h0000);
    rd(7'h02, 16'h0000);
    pg(8'h03);
    rd(7'h00, 16'h0003);
    rd(7'h06, 16'h0009);
    rd(7'h0a, 16'h00c0);
    rd(7'h0c, 16'h0000);
    rd(7'h16, 16'h0000);
    rd(7'h08, {12'h000, DIO_I});
    pg(8'h0d);
    rd(7'h00, 16'h0003);
    pg(8'h05);
    rd(7'h08, 16'h4000);
    pg(8'h06);
    rd(7'h08, 16'h0000);
    $display("test registers done");
    pg(8'h00);
    s1 = rnd();
    send(s1);
    wait_drdy();
    check_set(1, 1'b1, 1'b0);
    rd(7'h04, 16'h0001);
    $display("test linear g on done");
    pg(8'h03);
    wr(7'h0a, 16'h0040);
    rd(7'h0a, 16'h0040);
    pg(8'h00);
    s1 = rnd();
    send(s1);
    wait_drdy();
    check_set(1, 1'b0, 1'b0);
    $display("test linear g off done");
    pg(8'h05);
    wr(7'h08, 16'h2000);
    pg(8'h03);
    wr(7'h16, 16'h0004);
    pg(8'h00);
    s1 = rnd();
    send(s1);
    wait_drdy();
    check_set(1, 1'b0, 1'b1);
    $display("test fir bank done");
    pg(8'h03);
    wr(7'h0c, 16'h0001);
    s1 = rnd();
    s2 = rnd();
    send(s1);
    send(s2);
    wait_drdy();
    pg(8'h00);
    check_set(2, 1'b0, 1'b1);
    $display("test decimation done");
    pg(8'h03);
    wr(7'h0c, 16'h0000);
    k = 0;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    repeat (12) begin
      @(negedge CLK);
      tk = (SAMPLE_READY === 1'b1);
      k += int'(tk);
      @(posedge CLK);
      if (tk) SAMPLE_RAW <= rnd();
    end
    SAMPLE_VALID <= 1'b0;
    post(16'(k), 16'h0009);
    repeat (9) wait_drdy();
    @(negedge CLK);
    post({15'h0000, SAMPLE_READY}, 16'h0001);
    $display("test buffer fill done");
    end_sim();
  end
endmodule : imucf_top_tb
`default_nettype wire
